// ---- verilog/csf_report_framer.sv ----
// Swipe report framer: captures decoded tracks, serves the input report
`timescale 1ns/1ps
`include "csf_regs.svh"
module csf_report_framer
    import csf_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       trk_valid,
    input  wire logic [1:0] trk_sel,
    input  wire logic [7:0] trk_byte,
    input  wire logic       swipe_done,
    input  wire logic [2:0] swipe_signal,
    input  wire logic [2:0] swipe_decoded,
    input  wire logic [7:0] swipe_enc,
    output logic            cap_ready,
    input  wire logic       poll,
    output logic            nak,
    output logic            tx_valid,
    output logic [7:0]      tx_data,
    output logic            tx_last,
    input  wire logic       tx_ready,
    input  wire logic       ack,
    input  wire logic       retry,
    output logic            pending,
    input  wire logic [5:0] desc_addr,
    output logic [7:0]      desc_data
);
    csf_desc_if dsc ();

    csf_state_t  st_r,  st_nxt;
    csf_idx_t    idx_r, idx_nxt;
    logic        txv_r, txv_nxt;
    csf_byte_t   txd_r, txd_nxt;
    logic        nak_r, nak_nxt;
    logic [2:0]  err_r, err_nxt;
    csf_byte_t   len_r   [3];
    csf_byte_t   len_nxt [3];
    logic [6:0]  cnt_r   [3];
    logic [6:0]  cnt_nxt [3];
    csf_byte_t   enc_r, enc_nxt;
    csf_byte_t   dsc_r;
    csf_byte_t   mem_r [330];
    logic        wr_en;
    csf_idx_t    wr_idx;

    // Descriptor table lookup
    csf_desc_rom u_rom (
        .dsc (dsc.rom)
    );
    assign dsc.addr = desc_addr;

    // Track field base offset inside the capture store
    function automatic csf_idx_t trk_base(input logic [1:0] t);
        unique case (t)
            2'd0:    return 9'h000;
            2'd1:    return `CSF_TRK2_OFS;
            default: return `CSF_TRK3_OFS;
        endcase
    endfunction

    // Reserved codes and the never-sent none code fall to undetermined
    function automatic csf_byte_t enc_legal(input csf_byte_t e);
        if (e == `CSF_ENC_ISO || e == `CSF_ENC_AAMVA ||
            e == `CSF_ENC_BLANK || e == `CSF_ENC_OTHER) begin
            return e;
        end
        return `CSF_ENC_UNDET; // R16
    endfunction

    // Report byte at a given offset; beyond length reads zero
    function automatic csf_byte_t rpt_byte(input csf_idx_t i);
        csf_idx_t   off;
        logic [1:0] t;
        csf_idx_t   loc;
        off = i - `CSF_DATA_OFS;
        t   = 2'd2;
        loc = 9'h000;
        if (i < `CSF_LEN_OFS) begin
            return {7'h00, err_r[i[1:0]]}; // R11
        end
        if (i < `CSF_ENC_OFS) begin
            return len_r[2'(i - `CSF_LEN_OFS)];
        end
        if (i == `CSF_ENC_OFS) begin
            return enc_r;
        end
        if (off < `CSF_TRK2_OFS) begin
            t = 2'd0;
        end else if (off < `CSF_TRK3_OFS) begin
            t = 2'd1;
        end
        loc = off - trk_base(t);
        if (loc < {1'b0, len_r[t]}) begin
            return mem_r[off]; // R10
        end
        return 8'h00; // R15 R18
    endfunction

    // Capture store write; bytes past a full field are dropped
    always_comb begin
        wr_idx = trk_base(trk_sel) + 9'(cnt_r[trk_sel]);
        wr_en  = (st_r == CSF_ST_COLLECT) && trk_valid &&
                 (trk_sel != 2'd3) && (cnt_r[trk_sel] < `CSF_TRK_LEN);
    end

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem_r[wr_idx] <= trk_byte;
        end
    end

    // Report sequencer and field latches
    always_comb begin
        st_nxt  = st_r;
        idx_nxt = idx_r;
        txv_nxt = txv_r;
        txd_nxt = txd_r;
        nak_nxt = 1'b0;
        err_nxt = err_r;
        enc_nxt = enc_r;
        for (int k = 0; k < 3; k++) begin
            len_nxt[k] = len_r[k];
            cnt_nxt[k] = cnt_r[k];
        end
        unique case (st_r)
            CSF_ST_COLLECT: begin
                if (poll) begin
                    nak_nxt = 1'b1; // R8
                end
                if (wr_en) begin
                    cnt_nxt[trk_sel] = cnt_r[trk_sel] + 7'h01;
                end
                // Every swipe taken while collecting is framed, decodable or not
                if (swipe_done) begin // R9
                    for (int k = 0; k < 3; k++) begin
                        // Noise alone never flags an error
                        err_nxt[k] = swipe_signal[k] &
                                     ~swipe_decoded[k]; // R12
                        // Count includes a byte taken with the done pulse
                        len_nxt[k] = (swipe_decoded[k] && !err_nxt[k])
                                   ? {1'b0, cnt_nxt[k]} : 8'h00; // R13 R14
                    end
                    enc_nxt = enc_legal(swipe_enc); // R16
                    st_nxt  = CSF_ST_PEND;
                end
            end
            CSF_ST_PEND: begin
                // Report goes out only when the IN pipe is polled
                if (poll) begin // R6
                    idx_nxt = `CSF_STAT_OFS;
                    txd_nxt = rpt_byte(`CSF_STAT_OFS);
                    txv_nxt = 1'b1;
                    st_nxt  = CSF_ST_SEND;
                end
            end
            CSF_ST_SEND: begin
                // Whole report streams in one transfer, no split
                if (tx_ready) begin // R7
                    if (idx_r == `CSF_RPT_LAST) begin
                        txv_nxt = 1'b0;
                        st_nxt  = CSF_ST_WAIT;
                    end else begin
                        idx_nxt = idx_r + 9'h001;
                        txd_nxt = rpt_byte(idx_r + 9'h001);
                    end
                end
            end
            CSF_ST_WAIT: begin
                // Held until acknowledged; a lost transfer is resent
                if (ack) begin // R17
                    st_nxt = CSF_ST_COLLECT;
                    for (int k = 0; k < 3; k++) begin
                        cnt_nxt[k] = 7'h00;
                    end
                end else if (retry) begin // R7
                    st_nxt = CSF_ST_PEND;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_r  <= CSF_ST_COLLECT;
            idx_r <= 9'h000;
            txv_r <= 1'b0;
            txd_r <= 8'h00;
            nak_r <= 1'b0;
            err_r <= 3'h0;
            enc_r <= `CSF_ENC_NONE;
            for (int k = 0; k < 3; k++) begin
                len_r[k] <= 8'h00;
                cnt_r[k] <= 7'h00;
            end
        end else begin
            st_r  <= st_nxt;
            idx_r <= idx_nxt;
            txv_r <= txv_nxt;
            txd_r <= txd_nxt;
            nak_r <= nak_nxt;
            err_r <= err_nxt;
            enc_r <= enc_nxt;
            for (int k = 0; k < 3; k++) begin
                len_r[k] <= len_nxt[k];
                cnt_r[k] <= cnt_nxt[k];
            end
        end
    end

    // Descriptor data is registered, one cycle behind the address
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dsc_r <= 8'h00;
        end else begin
            dsc_r <= dsc.data;
        end
    end

    // Outputs
    assign cap_ready = (st_r == CSF_ST_COLLECT); // R17
    assign nak       = nak_r;
    assign tx_valid  = txv_r;
    assign tx_data   = txd_r;
    assign tx_last   = txv_r && (idx_r == `CSF_RPT_LAST);
    assign pending   = (st_r != CSF_ST_COLLECT);
    assign desc_data = dsc_r;
endmodule // csf_report_framer

// ---- verilog/csf_regs.svh ----
// Report layout, descriptor and code constants for the swipe report framer
// Function
// R1: All usages sit on vendor stripe-reader page, first descriptor item.
// R2: Usage IDs 20-22 status, 28-2A length, 30-32 data, 38 type, 20 cmd.
// R3: Descriptor opens application collection, range 0-255, size 8, ends C0.
// R4: Seven single-byte inputs, then three 110-byte buffered-byte inputs.
// R5: Command message is a 24-byte buffered-bytes feature item.
// R6: Swipe results leave only as an input report on interrupt IN.
// R7: Exactly one input report per swipe, no repeats, no splits.
// R8: Poll with no pending report is answered with NAK.
// R9: A swipe yields a report even when no track decodes.
// R10: Bytes 0-2 status, 3-5 length, 6 type, then three 110-byte fields.
// R11: Status bit 0 is decode error; bits 7 to 1 reserved zero.
// R12: Error only for non-noise signal that failed to decode.
// R13: Errored track reports length zero and no valid data.
// R14: Length equals decoded bytes placed; zero when track empty.
// R15: Field bytes beyond length are undefined; receiver ignores them.
// R16: Encode type is 0,1,3,4,5 or 6; value 2 reserved.
// R17: Hold report pending until host acknowledges; then accept next swipe.
// R18: Unused track field bytes are sent as zero.
`ifndef CSF_REGS_SVH
`define CSF_REGS_SVH

// Input report layout (byte offsets)
`define CSF_STAT_OFS   9'h000
`define CSF_LEN_OFS    9'h003
`define CSF_ENC_OFS    9'h006
`define CSF_DATA_OFS   9'h007
`define CSF_RPT_LAST   9'h150
`define CSF_TRK2_OFS   9'h06e
`define CSF_TRK3_OFS   9'h0dc
`define CSF_TRK_LEN    7'h6e
`define CSF_MEM_LAST   9'h149
`define CSF_ERR_BIT    0

// Encode type codes
`define CSF_ENC_ISO    8'h00
`define CSF_ENC_AAMVA  8'h01
`define CSF_ENC_BLANK  8'h03
`define CSF_ENC_OTHER  8'h04
`define CSF_ENC_UNDET  8'h05
`define CSF_ENC_NONE   8'h06

// Report descriptor size in bytes
`define CSF_DESC_LEN   6'h3d
`define CSF_DESC_LAST  6'h3c

`endif

// ---- verilog/csf_pkg.sv ----
// Types shared by the swipe report framer modules
package csf_pkg;
    typedef logic [7:0] csf_byte_t;
    typedef logic [8:0] csf_idx_t;
    typedef logic [5:0] csf_daddr_t;
    typedef enum logic [1:0] {
        CSF_ST_COLLECT,
        CSF_ST_PEND,
        CSF_ST_SEND,
        CSF_ST_WAIT
    } csf_state_t;
endpackage

// ---- verilog/csf_desc_if.sv ----
// Descriptor lookup channel between framer and descriptor table
`timescale 1ns/1ps
interface csf_desc_if;
    import csf_pkg::*;
    csf_daddr_t addr;
    csf_byte_t  data;
    modport rom  (input addr, output data);
    modport user (output addr, input data);
endinterface

// ---- verilog/csf_desc_rom.sv ----
// Constant HID report descriptor table, read by byte index
`timescale 1ns/1ps
`include "csf_regs.svh"
module csf_desc_rom
    import csf_pkg::*;
(
    csf_desc_if.rom dsc
);
    // First descriptor byte sits in the top byte of the table
    localparam logic [487:0] DESC = {
        8'h06, 8'h00, 8'hff,                        // R1
        8'h09, 8'h01, 8'ha1, 8'h01,                 // R3
        8'h15, 8'h00, 8'h26, 8'hff, 8'h00,          // R3
        8'h75, 8'h08,                               // R3
        8'h09, 8'h20, 8'h09, 8'h21, 8'h09, 8'h22,   // R2
        8'h09, 8'h28, 8'h09, 8'h29, 8'h09, 8'h2a,   // R2
        8'h09, 8'h38, 8'h95, 8'h07, 8'h81, 8'h02,   // R4
        8'h09, 8'h30, 8'h95, 8'h6e, 8'h82, 8'h02, 8'h01, // R4
        8'h09, 8'h31, 8'h95, 8'h6e, 8'h82, 8'h02, 8'h01, // R4
        8'h09, 8'h32, 8'h95, 8'h6e, 8'h82, 8'h02, 8'h01, // R4
        8'h09, 8'h20, 8'h95, 8'h18, 8'hb2, 8'h02, 8'h01, // R5
        8'hc0                                       // R3
    };

    // Out-of-range index reads zero rather than wrapping
    function automatic csf_byte_t desc_byte(input csf_daddr_t a);
        logic [5:0] r;
        r = `CSF_DESC_LAST - a;
        if (a > `CSF_DESC_LAST) begin
            return 8'h00;
        end
        return DESC[{r, 3'b000} +: 8];
    endfunction

    assign dsc.data = desc_byte(dsc.addr);
endmodule // csf_desc_rom

// ---- verification/csf_report_framer_props.sv ----
// Port checks for the swipe report framer
`timescale 1ns/1ps
module csf_report_framer_props (
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       swipe_done,
    input wire logic       cap_ready,
    input wire logic       poll,
    input wire logic       nak,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_last,
    input wire logic       tx_ready,
    input wire logic       ack,
    input wire logic       retry,
    input wire logic       pending,
    input wire logic [5:0] desc_addr,
    input wire logic [7:0] desc_data
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // Reply timing on the IN pipe
    nak_idle_a: assert property (poll && !pending |=> nak)
        else $error("no nak on idle poll");
    nak_clean_a: assert property (nak |-> !pending && !tx_valid)
        else $error("nak with report");
    hold_pend_a: assert property (swipe_done && cap_ready |=> pending)
        else $error("swipe not held");
    // Nothing leaves while capture is open
    pend_block_a: assert property (cap_ready |-> !tx_valid && !tx_last)
        else $error("bytes sent while collecting");
    byte_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte lost on stall");
    frame_end_a: assert property (
        tx_valid && tx_ready && tx_last |=> !tx_valid)
        else $error("bytes after last");
    // Acknowledge frees the report, retry keeps it
    ack_free_a: assert property (
        $past(tx_valid && tx_ready && tx_last) && ack
        |=> cap_ready && !pending)
        else $error("ack ignored");
    retry_keep_a: assert property (
        $past(tx_valid && tx_ready && tx_last) && retry
        |=> pending && !tx_valid)
        else $error("retry dropped report");
    desc_head_a: assert property (
        desc_addr == 6'h00 |=> desc_data == 8'h06)
        else $error("bad first item");
    desc_tail_a: assert property (
        desc_addr == 6'h3c |=> desc_data == 8'hc0)
        else $error("bad end item");
endmodule // csf_report_framer_props
bind csf_report_framer csf_report_framer_props props_i (.*);

// ---- verification/csf_host_model.sv ----
// Host side of the IN pipe: polls and collects one report
`timescale 1ns/1ps
module csf_host_model (
    input  wire logic       clock,
    input  wire logic       req,
    input  wire logic       slow,
    input  wire logic       rty,
    input  wire logic       nak,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            poll,
    output logic            tx_ready,
    output logic            ack,
    output logic            retry,
    output logic            busy,
    output logic            got_nak
);
    logic [7:0] rpt [337];
    int         cnt;
    initial begin
        {poll, tx_ready, ack, retry, busy, got_nak} = '0;
    end
    // One poll; a NAK ends the visit, else take 337 bytes then answer
    always @(posedge clock) begin
        if (req) begin
            busy = 1'b1;
            #1 poll = 1'b1;
            @(posedge clock) #1 poll = 1'b0;
            @(posedge clock) got_nak = nak;
            cnt = 0;
            while (!got_nak && cnt < 337) begin
                #1 tx_ready = !slow || !tx_ready; // Slow stalls every other
                @(posedge clock);
                if (tx_valid && tx_ready) begin
                    rpt[cnt] = tx_data;
                    cnt++;
                end
            end
            #1 tx_ready = 1'b0;
            ack = !got_nak && !rty;
            retry = !got_nak && rty;
            @(posedge clock) #1;
            {ack, retry, busy} = '0;
        end
    end
endmodule // csf_host_model

// ---- verification/card_swipe_report_framer_test.sv ----
// Self-checking bench for the swipe report framer
`timescale 1ns/1ps
module card_swipe_report_framer_test;
    import csf_pkg::*;
    typedef struct packed {
        logic [7:0] n;
        logic [2:0] s, d;
        logic [7:0] e, x;
    } csf_row_t;
    logic       clock, resetn, trk_valid, swipe_done, poll, tx_ready;
    logic       ack, retry, req, slow, rty, cap_ready, nak, tx_valid;
    logic       tx_last, pending, busy, got_nak;
    logic [1:0] trk_sel;
    logic [2:0] swipe_signal, swipe_decoded;
    logic [5:0] desc_addr;
    logic [7:0] trk_byte, swipe_enc, tx_data, desc_data;
    int         err_count, check_count, cyc;
    // Bytes per track, signal, decoded, code in, code out
    csf_row_t rows [7] = '{'{5, 7, 7, 0, 0}, '{110, 7, 3, 1, 1},
        '{112, 1, 1, 4, 4}, '{3, 7, 0, 5, 5}, '{4, 0, 0, 3, 3},
        '{0, 7, 7, 2, 5}, '{1, 2, 2, 6, 5}};
    // Descriptor spot values: index, byte
    logic [13:0] dsc [12] = '{14'h0006, 14'h02ff, 14'h05a1, 14'h0d08,
        14'h192a, 14'h1b38, 14'h1d07, 14'h236e, 14'h2482, 14'h39b2,
        14'h3cc0, 14'h3d00};
    csf_report_framer uut (.*);
    csf_host_model host (.*);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Hang guard, about four times the expected run
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    task chk(input string nm, input logic [7:0] s, e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task swipe(input csf_row_t r);
        for (int k = 0; k < 3; k++)
            for (int i = 0; i < r.n; i++) begin
                @(posedge clock) #1;
                {trk_valid, trk_sel, trk_byte} = {1'b1, 2'(k), 8'(i + k)};
            end
        @(posedge clock) #1;
        trk_valid = 1'b0;
        {swipe_done, swipe_signal, swipe_decoded} = {1'b1, r.s, r.d};
        swipe_enc = r.e;
        @(posedge clock) #1;
        swipe_done = 1'b0;
    endtask
    task read(input logic sl, rt);
        @(posedge clock) #1;
        {req, slow, rty} = {1'b1, sl, rt};
        @(posedge clock) #1;
        req = 1'b0;
        @(posedge clock);
        while (busy) @(posedge clock);
    endtask
    task cmp(input csf_row_t r);
        logic [7:0] ln, x;
        int k, j;
        ln = (r.n > 110) ? 8'd110 : r.n; // Excess bytes dropped
        for (int i = 0; i < 337; i++) begin
            k = (i < 7) ? 0 : (i - 7) / 110;
            j = (i - 7) % 110;
            if (i < 3) x = {7'h0, r.s[i] & ~r.d[i]};
            else if (i < 6) x = r.d[i - 3] ? ln : 8'h00;
            else if (i == 6) x = r.x;
            else x = (r.d[k] && j < ln) ? 8'(j + k) : 8'h00;
            chk("report", host.rpt[i], x);
        end
    endtask
    initial begin
        {resetn, trk_valid, swipe_done, req, slow, rty} = '0;
        {trk_sel, trk_byte, swipe_signal, swipe_decoded} = '0;
        {swipe_enc, desc_addr} = '0;
        repeat (8) @(posedge clock);
        chk("cap_ready", 8'(cap_ready), 8'h01);
        chk("pending", 8'(pending), 8'h00);
        #1 resetn = 1'b1;
        foreach (dsc[m]) begin
            @(posedge clock) #1 desc_addr = dsc[m][13:8];
            @(posedge clock) #1;
            chk("desc", desc_data, dsc[m][7:0]);
        end
        $display("descriptor test done");
        read(1'b0, 1'b0);
        chk("nak", 8'(got_nak), 8'h01);
        foreach (rows[m]) begin
            swipe(rows[m]);
            read(1'b0, 1'b0);
            chk("nak", 8'(got_nak), 8'h00);
            cmp(rows[m]);
        end
        $display("row test done");
        // Second swipe while held is dropped; retry resends
        swipe(rows[1]);
        swipe(rows[0]);
        read(1'b1, 1'b1);
        cmp(rows[1]);
        read(1'b0, 1'b0);
        cmp(rows[1]);
        read(1'b0, 1'b0);
        chk("nak", 8'(got_nak), 8'h01);
        $display("hold and retry test done");
        // Reset while a report is held drops it; next poll is refused
        swipe(rows[0]);
        resetn = 1'b0;
        @(posedge clock) #1;
        chk("pending", 8'(pending), 8'h00);
        resetn = 1'b1;
        read(1'b0, 1'b0);
        chk("nak", 8'(got_nak), 8'h01);
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule // card_swipe_report_framer_test
